// ---- verilog/pin_change_pkg.sv ----
package pin_change_pkg;
  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned ADDR_WIDTH = 12;
  // byte addresses of the register words
  localparam logic [11:0] OFFSET_RISING = 12'h000;
  localparam logic [11:0] OFFSET_FALLING = 12'h004;
  localparam logic [11:0] OFFSET_FLAGS = 12'h008;
  localparam logic [11:0] OFFSET_CONTROL = 12'h00C;
  // interrupt_control_reg fields
  localparam int unsigned CTRL_SUMMARY_BIT = 0;
  localparam int unsigned CTRL_MASTER_BIT = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_SETUP = 2'b01,
    ACC_ACCESS = 2'b10
  } apb_phase_t;
endpackage

// ---- verilog/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser with a third stage kept for edge comparison
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] synced,
  output logic [WIDTH-1:0] previous
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      synced <= '0;
      previous <= '0;
    end else begin
      meta <= raw;
      synced <= meta;
      previous <= synced;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/edge_cell.sv ----
`timescale 1ns/1ps
`default_nettype none
// per-pin rising and falling detectors
module edge_cell #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic [WIDTH-1:0] synced,
  input wire logic [WIDTH-1:0] previous,
  input wire logic [WIDTH-1:0] rising_edge_enable,
  input wire logic [WIDTH-1:0] falling_edge_enable,
  output logic [WIDTH-1:0] hit
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      // either detector may fire; both enabled gives any-polarity sense
      assign hit[i] = (rising_edge_enable[i] & synced[i] & ~previous[i])
        | (falling_edge_enable[i] & ~synced[i] & previous[i]);
    end
  endgenerate
endmodule
`default_nettype wire

// ---- verilog/pin_change_edge_detector.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - per-pin rising detector gated by enable
// - per-pin falling detector gated by enable
// - both enables detect either polarity
// - only enabled edges or a written one set pin flag
// - interrupt needs a flag and master enable
// - summary flag is OR of flags
// - writing zero clears a flag
// - edge during write keeps flag set
// - enabled edge in sleep requests wake when master enable is set
// - sleep edge recorded before resuming
// - rising enable 8 bits, reset zero
// - falling enable 8 bits, reset zero
// - flag register RW, hardware set, reset zero
// - detection continues with master enable off
// - master enable lives in control register
module pin_change_edge_detector #(
  parameter int unsigned PINS = pin_change_pkg::PIN_COUNT
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pin_change_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port pins and system
  input wire logic [PINS-1:0] sensed_port,
  input wire logic sleep_active,
  output logic change_irq,
  output logic wake_request
);
  logic [PINS-1:0] rising_edge_enable;
  logic [PINS-1:0] falling_edge_enable;
  logic [PINS-1:0] edge_detected_flags;
  logic change_irq_master_enable;
  logic [PINS-1:0] synced;
  logic [PINS-1:0] previous;
  logic [PINS-1:0] hit;
  logic change_irq_summary_flag;
  logic setup_phase;
  logic wr_fire;
  logic rd_fire;
  logic byte0;
  logic mapped;
  logic [31:0] next_rdata;

  pin_sync #(.WIDTH(PINS)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw(sensed_port),
    .synced(synced),
    .previous(previous)
  );

  edge_cell #(.WIDTH(PINS)) u_edge (
    .synced(synced),
    .previous(previous),
    .rising_edge_enable(rising_edge_enable),
    .falling_edge_enable(falling_edge_enable),
    .hit(hit)
  );

  // the slave adds no wait state; pready rises in the first access cycle and read data comes from a flop
  assign setup_phase = psel & ~penable;
  assign wr_fire = psel & penable & pready & pwrite;
  assign rd_fire = psel & penable & pready & ~pwrite;
  assign byte0 = pstrb[0];
  assign mapped = (paddr == pin_change_pkg::OFFSET_RISING)
    | (paddr == pin_change_pkg::OFFSET_FALLING)
    | (paddr == pin_change_pkg::OFFSET_FLAGS)
    | (paddr == pin_change_pkg::OFFSET_CONTROL);
  assign change_irq_summary_flag = |edge_detected_flags;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_phase & ~mapped;
    end
  end

  AST_READY_AFTER_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase |=> pready)
    else $error("no ready after setup");

  AST_READY_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held past access");

  AST_READY_NEEDS_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> $past(setup_phase))
    else $error("ready without setup");

  AST_ERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !mapped) |=> (pready && pslverr))
    else $error("unmapped access without error");

  AST_ERR_MAPPED_CLEAN: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && mapped) |=> !pslverr)
    else $error("error on mapped access");

  AST_ERR_ONLY_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error outside access phase");

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rising_edge_enable <= '0;
      falling_edge_enable <= '0;
      change_irq_master_enable <= 1'b0;
    end else if (wr_fire && byte0) begin
      case (paddr)
        pin_change_pkg::OFFSET_RISING: rising_edge_enable <= pwdata[PINS-1:0];
        pin_change_pkg::OFFSET_FALLING: falling_edge_enable <= pwdata[PINS-1:0];
        pin_change_pkg::OFFSET_CONTROL: begin
          change_irq_master_enable <= pwdata[pin_change_pkg::CTRL_MASTER_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  AST_RISING_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && byte0 && paddr == pin_change_pkg::OFFSET_RISING)
    |=> rising_edge_enable == $past(pwdata[PINS-1:0]))
    else $error("rising enable write lost");

  AST_FALLING_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && byte0 && paddr == pin_change_pkg::OFFSET_FALLING)
    |=> falling_edge_enable == $past(pwdata[PINS-1:0]))
    else $error("falling enable write lost");

  AST_MASTER_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && byte0 && paddr == pin_change_pkg::OFFSET_CONTROL)
    |=> change_irq_master_enable == $past(pwdata[pin_change_pkg::CTRL_MASTER_BIT]))
    else $error("master enable write lost");

  // a write with lane 0 off must leave the enables alone
  AST_STROBE_GUARD: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && !byte0) |=> ($stable(rising_edge_enable) && $stable(falling_edge_enable)))
    else $error("write without lane 0 changed an enable");

  AST_UNMAPPED_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && pslverr) |=> ($stable(rising_edge_enable) && $stable(falling_edge_enable)
      && $stable(change_irq_master_enable)))
    else $error("unmapped write changed a register");

  // flags: a detected edge wins over any software write in the same cycle;
  // sensing runs whether or not the master enable is set, and in sleep too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_detected_flags <= '0;
    end else if (wr_fire && byte0 && paddr == pin_change_pkg::OFFSET_FLAGS) begin
      edge_detected_flags <= pwdata[PINS-1:0] | hit;
    end else begin
      edge_detected_flags <= edge_detected_flags | hit;
    end
  end

  AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_detected_flags[0] && !(wr_fire && byte0 && paddr == pin_change_pkg::OFFSET_FLAGS))
    |=> edge_detected_flags[0])
    else $error("flag dropped without a write");

  AST_WRITE_ONE_SETS: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && byte0 && paddr == pin_change_pkg::OFFSET_FLAGS && pwdata[3])
    |=> edge_detected_flags[3])
    else $error("written one did not stick");

  always_comb begin
    next_rdata = pin_change_pkg::READ_ZERO;
    case (paddr)
      pin_change_pkg::OFFSET_RISING: next_rdata[PINS-1:0] = rising_edge_enable;
      pin_change_pkg::OFFSET_FALLING: next_rdata[PINS-1:0] = falling_edge_enable;
      pin_change_pkg::OFFSET_FLAGS: next_rdata[PINS-1:0] = edge_detected_flags;
      pin_change_pkg::OFFSET_CONTROL: begin
        next_rdata[pin_change_pkg::CTRL_MASTER_BIT] = change_irq_master_enable;
        next_rdata[pin_change_pkg::CTRL_SUMMARY_BIT] = change_irq_summary_flag;
      end
      default: next_rdata = pin_change_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= pin_change_pkg::READ_ZERO;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // read data is taken at the setup edge, so it shows the setup-cycle state
  AST_READ_RISING: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_fire && paddr == pin_change_pkg::OFFSET_RISING)
    |-> prdata[PINS-1:0] == $past(rising_edge_enable))
    else $error("rising enable read differs");

  AST_READ_FALLING: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_fire && paddr == pin_change_pkg::OFFSET_FALLING)
    |-> prdata[PINS-1:0] == $past(falling_edge_enable))
    else $error("falling enable read differs");

  AST_READ_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_fire && paddr == pin_change_pkg::OFFSET_FLAGS)
    |-> prdata[PINS-1:0] == $past(edge_detected_flags))
    else $error("flag read differs");

  AST_READ_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    rd_fire |-> prdata[31:PINS] == '0)
    else $error("upper read bits not zero");

  AST_READ_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_fire && pslverr) |-> prdata == pin_change_pkg::READ_ZERO)
    else $error("unmapped read not zero");

  AST_READ_MASTER: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_fire && paddr == pin_change_pkg::OFFSET_CONTROL)
    |-> prdata[pin_change_pkg::CTRL_MASTER_BIT] == $past(change_irq_master_enable))
    else $error("master enable read differs");

  // the irq follows the flags OR hit, so it rises with a flag set by an edge and comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_irq <= 1'b0;
    end else begin
      change_irq <= change_irq_master_enable & (|(edge_detected_flags | hit));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= sleep_active & change_irq_master_enable & (|hit);
    end
  end

  sequence s_edge_seen;
    |hit;
  endsequence

  sequence s_flag_up;
    ##1 (|edge_detected_flags);
  endsequence

  // pin 0 changes at the port; the detector must be armed when the
  // synchronised copy reaches the compare stage two cycles later
  sequence s_pin0_rose;
    !sensed_port[0] ##1 sensed_port[0];
  endsequence

  sequence s_pin0_fell;
    sensed_port[0] ##1 !sensed_port[0];
  endsequence

  AST_RISE_SETS_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (rising_edge_enable[0] && synced[0] && !previous[0]) |=> edge_detected_flags[0])
    else $error("rising edge did not set flag");

  AST_FALL_SETS_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (falling_edge_enable[0] && !synced[0] && previous[0]) |=> edge_detected_flags[0])
    else $error("falling edge did not set flag");

  AST_BOTH_POLARITY: assert property (@(posedge pclk) disable iff (!presetn)
    (rising_edge_enable[0] && falling_edge_enable[0] && synced[0] != previous[0])
    |=> edge_detected_flags[0])
    else $error("dual enable missed an edge");

  AST_NO_SPURIOUS_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (!edge_detected_flags[0] && !hit[0]
      && !(wr_fire && byte0 && paddr == pin_change_pkg::OFFSET_FLAGS && pwdata[0]))
    |=> !edge_detected_flags[0])
    else $error("flag set without enabled edge");

  AST_IRQ_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    change_irq |-> $past(change_irq_master_enable))
    else $error("irq raised with master enable off");

  AST_IRQ_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
    (change_irq_master_enable && (|edge_detected_flags)) |=> change_irq)
    else $error("irq missing with flag and enable");

  AST_SUMMARY_OR: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_fire && paddr == pin_change_pkg::OFFSET_CONTROL)
    |-> prdata[pin_change_pkg::CTRL_SUMMARY_BIT] == $past(|edge_detected_flags))
    else $error("summary flag differs from flags");

  AST_WRITE_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && byte0 && paddr == pin_change_pkg::OFFSET_FLAGS && !pwdata[0] && !hit[0])
    |=> !edge_detected_flags[0])
    else $error("zero write did not clear flag");

  AST_SET_BEATS_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && paddr == pin_change_pkg::OFFSET_FLAGS && hit[0]) |=> edge_detected_flags[0])
    else $error("edge lost during flag write");

  AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_active && change_irq_master_enable && (|hit)) |=> wake_request)
    else $error("no wake request on sleep edge");

  AST_SLEEP_RECORD: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_active and s_edge_seen) |-> s_flag_up)
    else $error("sleep edge not recorded");

  AST_DETECT_NO_MASTER: assert property (@(posedge pclk) disable iff (!presetn)
    (!change_irq_master_enable and s_edge_seen) |-> s_flag_up)
    else $error("detection stopped with master off");

  AST_RISE_LATENCY: assert property (@(posedge pclk) disable iff (!presetn)
    (s_pin0_rose ##2 rising_edge_enable[0]) |=> edge_detected_flags[0])
    else $error("rising pin not flagged in time");

  AST_FALL_LATENCY: assert property (@(posedge pclk) disable iff (!presetn)
    (s_pin0_fell ##2 falling_edge_enable[0]) |=> edge_detected_flags[0])
    else $error("falling pin not flagged in time");

  AST_IRQ_NEEDS_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    change_irq |-> ($past(|edge_detected_flags) || (|edge_detected_flags)))
    else $error("irq without a flag");

  AST_NO_WAKE_AWAKE: assert property (@(posedge pclk) disable iff (!presetn)
    !sleep_active |=> !wake_request)
    else $error("wake request while awake");

  AST_NO_WAKE_MASTER_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !change_irq_master_enable |=> !wake_request)
    else $error("wake request with master enable off");
endmodule
`default_nettype wire

// ---- verification/pin_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// far-side pin levels; they change only just after a clock edge
module pin_source (
  // clock
  input wire logic pclk,
  // pins
  output var logic [7:0] pins
);
  initial pins = 8'h00;
  task automatic drive(input logic [7:0] v);
    @(posedge pclk);
    pins <= v;
  endtask
endmodule
`default_nettype wire

// ---- verification/pin_change_edge_detector_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_change_edge_detector_tb;
  localparam logic [11:0] RA = pin_change_pkg::OFFSET_RISING;
  localparam logic [11:0] FA = pin_change_pkg::OFFSET_FALLING;
  localparam logic [11:0] GA = pin_change_pkg::OFFSET_FLAGS;
  localparam logic [11:0] CA = pin_change_pkg::OFFSET_CONTROL;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic sleep_active = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic change_irq;
  logic wake_request;
  wire logic [7:0] sensed_port;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] q;
  logic e;
  logic seen;
  always #12.5 pclk = ~pclk;
  pin_source pins (.pclk(pclk), .pins(sensed_port));
  pin_change_edge_detector uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sensed_port(sensed_port),
    .sleep_active(sleep_active), .change_irq(change_irq), .wake_request(wake_request));
  task automatic conclude();
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is sampled high, answer taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t no pready", $time);
      conclude();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic pin_step(input logic [7:0] v);
    pins.drive(v);
    repeat (5) @(posedge pclk);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(RA, 32'h0);
    rd(FA, 32'h0);
    rd(GA, 32'h0);
    rd(CA, 32'h0);
    apb(1'b1, RA, 32'h0F);
    apb(1'b1, FA, 32'hF0);
    pstrb <= 4'h0;
    apb(1'b1, RA, 32'hFF);
    pstrb <= 4'hF;
    rd(RA, 32'h0F);
    rd(FA, 32'hF0);
    pin_step(8'hFF);
    rd(GA, 32'h0F);
    chk({31'h0, change_irq}, 32'h0);
    rd(CA, 32'h01);
    pin_step(8'h00);
    rd(GA, 32'hFF);
    apb(1'b0, GA, 32'h0);
    apb(1'b1, GA, q & ~32'hF0);
    rd(GA, 32'h0F);
    apb(1'b1, GA, 32'h0);
    rd(CA, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, 12'h010, 32'hFF);
    chk({31'h0, e}, 32'h1);
    rd(RA, 32'h0F);
    apb(1'b1, RA, 32'h01);
    apb(1'b1, FA, 32'h01);
    pin_step(8'h01);
    rd(GA, 32'h01);
    apb(1'b1, GA, 32'h0);
    pin_step(8'h00);
    rd(GA, 32'h01);
    apb(1'b1, GA, 32'h0);
    // edge lands on the clearing write's own edge
    pins.drive(8'h01);
    apb(1'b1, GA, 32'h0);
    rd(GA, 32'h01);
    apb(1'b1, CA, 32'h10);
    repeat (2) @(posedge pclk);
    chk({31'h0, change_irq}, 32'h1);
    rd(CA, 32'h11);
    apb(1'b1, GA, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, change_irq}, 32'h0);
    sleep_active <= 1'b1;
    pins.drive(8'h00);
    seen = 1'b0;
    repeat (10) begin
      @(posedge pclk);
      if (wake_request === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h1);
    sleep_active <= 1'b0;
    rd(GA, 32'h01);
    conclude();
  end
endmodule
`default_nettype wire
